// >>> src/ihc_top.sv
// Interrupt and halt control: masks, flags, dispatch and APB registers
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ihc_top #(
  parameter int HALF_TICKS = ihc_pkg::FAST_HALF_CYC
) (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        SRST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Key input pins and stopwatch events
  input  wire logic [3:0]  KEY_INPUT_LINES_I,
  input  wire logic [1:0]  STOPWATCH_SET_I,
  // Core instruction events
  input  wire logic        INSTR_BOUNDARY_I,
  input  wire logic        GLOBAL_UNMASK_INSTR_I,
  input  wire logic        GLOBAL_MASK_INSTR_I,
  input  wire logic        HALT_INSTR_I,
  input  wire logic [11:0] RETURN_PC_I,
  input  wire logic [7:0]  STACK_PTR_I,
  // Core control
  output logic             CORE_CLK_EN_O,
  output logic             GIE_O,
  output logic             PC_LOAD_O,
  output logic      [11:0] PROGRAM_COUNTER_O,
  output logic      [3:0]  NEXT_PAGE_POINTER_O,
  // Stack writes and stack pointer update
  output logic             STACK_WE_O,
  output logic      [7:0]  STACK_ADDR_O,
  output logic      [3:0]  STACK_DATA_O,
  output logic             SP_LOAD_O,
  output logic      [7:0]  SP_VALUE_O
);
  import ihc_pkg::*;

  // Register index decode, invalid for misaligned or high addresses
  function automatic logic [8:0] idx_of(input logic [11:0] a);
    idx_of = {(a[1:0] == 2'h0) && (a[11:10] == 2'h0), a[9:2]};
  endfunction : idx_of

  // Known register index test
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_KEY_MASK) || (i == IDX_TMR_MASK) ||
                (i == IDX_KEY_FLAG) || (i == IDX_TMR_FLAG) ||
                (i == IDX_STATUS)   || (i == IDX_SW_FLAG);
  endfunction : is_mapped

  ihc_flag_if fif ();

  // Subblocks
  ihc_timer #(
    .HALF_TICKS (HALF_TICKS)
  ) u_timer (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .fif    (fif.tmr)
  );

  ihc_flags u_flags (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .fif    (fif.flg)
  );

  // Synchroniser and key edge state
  logic [3:0] key_meta_reg;
  logic [3:0] key_sync_reg;
  logic [3:0] key_armed_reg;
  logic [3:0] key_armed_next;

  // Register file
  logic [3:0] key_mask_reg;
  logic [3:0] key_mask_next;
  logic [2:0] tmr_mask_reg;
  logic [2:0] tmr_mask_next;
  logic       gie_reg;
  logic       gie_next;

  // APB response
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic [5:0]  rclr_reg;
  logic [5:0]  rclr_next;

  // Sequencer
  ihc_state_e  state_reg;
  ihc_state_e  state_next;
  logic [1:0]  push_cnt_reg;
  logic [1:0]  push_cnt_next;
  logic [11:0] ret_pc_reg;
  logic [11:0] ret_pc_next;
  logic [11:0] halt_pc_reg;
  logic [11:0] halt_pc_next;
  logic [7:0]  sp_base_reg;
  logic [7:0]  sp_base_next;
  logic [7:0]  step_reg;
  logic [7:0]  step_next;

  // Core-side outputs
  logic        pc_load_reg;
  logic        pc_load_next;
  logic [11:0] pc_reg;
  logic [11:0] pc_next;
  logic [3:0]  npp_reg;
  logic [3:0]  npp_next;
  logic        st_we_reg;
  logic        st_we_next;
  logic [7:0]  st_addr_reg;
  logic [7:0]  st_addr_next;
  logic [3:0]  st_data_reg;
  logic [3:0]  st_data_next;
  logic        sp_load_reg;
  logic        sp_load_next;
  logic [7:0]  sp_val_reg;
  logic [7:0]  sp_val_next;

  // Combinational helpers
  logic [8:0]  idx;
  logic        setup;
  logic        access;
  logic [3:0]  key_en_lvl;
  logic        timer_req;
  logic        key_req;
  logic        irq;
  logic        accept;

  // Key line synchroniser
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      key_meta_reg <= 4'h0;
      key_sync_reg <= 4'h0;
    end else begin
      key_meta_reg <= KEY_INPUT_LINES_I;
      key_sync_reg <= key_meta_reg;
    end
  end

  // only enabled lines reach the flag
  always_comb begin
    key_en_lvl     = key_sync_reg & key_mask_reg;
    key_armed_next = key_en_lvl;
  end

  // unmasking a high line counts as a rise
  always_comb begin
    fif.key_set = |(key_en_lvl & ~key_armed_reg);
  end

  // stopwatch events set flags without masks
  always_comb begin
    fif.sw_set = STOPWATCH_SET_I;
  end

  // timer request needs flag and mask, key request only its flag; both need enable
  always_comb begin
    timer_req = |(fif.flag_v[FLG_TMR_LSB +: 3] & tmr_mask_reg);
    key_req   = fif.flag_v[FLG_KEY];
    irq       = gie_reg & (timer_req | key_req);
  end

  // sample only at boundaries or while halted
  always_comb begin
    accept = irq & (((state_reg == ST_RUN) & INSTR_BOUNDARY_I) |
                    (state_reg == ST_HALT));
  end

  // APB phase decode
  always_comb begin
    idx    = idx_of(PADDR_I);
    setup  = PSEL_I & ~PENABLE_I;
    access = PSEL_I & PENABLE_I;
  end

  // Read data captured in setup, one wait-free access phase
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    rclr_next  = rclr_reg;
    if (setup) begin
      rdata_next = 32'h0;
      rclr_next  = 6'h0;
      err_next   = ~idx[8] | ~is_mapped(idx[7:0]);
      if (idx[8]) begin
        case (idx[7:0])
          IDX_KEY_MASK: begin
            rdata_next[3:0] = key_mask_reg;
          end
          IDX_TMR_MASK: begin
            rdata_next[2:0] = tmr_mask_reg;
          end
          IDX_KEY_FLAG: begin
            rdata_next[0] = fif.flag_v[FLG_KEY];
            rclr_next[FLG_KEY] = ~PWRITE_I & fif.flag_v[FLG_KEY];
          end
          IDX_TMR_FLAG: begin
            rdata_next[2:0] = fif.flag_v[FLG_TMR_LSB +: 3];
            rclr_next[FLG_TMR_LSB +: 3] =
              {3{~PWRITE_I}} & fif.flag_v[FLG_TMR_LSB +: 3];
          end
          IDX_SW_FLAG: begin
            rdata_next[1:0] = fif.flag_v[FLG_SW_LSB +: 2];
            rclr_next[FLG_SW_LSB +: 2] =
              {2{~PWRITE_I}} & fif.flag_v[FLG_SW_LSB +: 2];
          end
          IDX_STATUS: begin
            rdata_next[ST_GIE_BIT]  = gie_reg;
            rdata_next[ST_HALT_BIT] = (state_reg == ST_HALT);
            rdata_next[ST_PEND_BIT] = timer_req | key_req;
          end
          default: begin
            rdata_next = 32'h0;
          end
        endcase
      end
    end
  end

  // clear only the flags that were returned
  always_comb begin
    fif.clr_v = (access & ~PWRITE_I) ? rclr_reg : 6'h0;
  end

  // Mask writes at the completing edge
  always_comb begin
    key_mask_next = key_mask_reg;
    tmr_mask_next = tmr_mask_reg;
    if (access & PWRITE_I & idx[8]) begin
      if (idx[7:0] == IDX_KEY_MASK) begin
        key_mask_next = PWDATA_I[3:0];
      end
      if (idx[7:0] == IDX_TMR_MASK) begin
        tmr_mask_next = PWDATA_I[2:0];
      end
    end
  end

  // Global enable flag
  always_comb begin
    gie_next = gie_reg;
    if (GLOBAL_UNMASK_INSTR_I) begin
      gie_next = 1'b1;
    end
    if (GLOBAL_MASK_INSTR_I) begin
      gie_next = 1'b0;
    end
    if (accept) begin
      gie_next = 1'b0;
    end
  end

  // Dispatch sequencer
  always_comb begin
    state_next    = state_reg;
    push_cnt_next = push_cnt_reg;
    ret_pc_next   = ret_pc_reg;
    halt_pc_next  = halt_pc_reg;
    sp_base_next  = sp_base_reg;
    step_next     = step_reg;
    pc_load_next  = 1'b0;
    pc_next       = pc_reg;
    npp_next      = npp_reg;
    st_we_next    = 1'b0;
    st_addr_next  = st_addr_reg;
    st_data_next  = st_data_reg;
    sp_load_next  = 1'b0;
    sp_val_next   = sp_val_reg;
    if (accept) begin
      if (timer_req & key_req) begin
        step_next = STEP_BOTH;
      end else if (key_req) begin
        step_next = STEP_KEY;
      end else begin
        step_next = STEP_TIMER;
      end
      // halted core resumes after the halt
      ret_pc_next   = (state_reg == ST_HALT) ? halt_pc_reg : RETURN_PC_I;
      sp_base_next  = STACK_PTR_I;
      push_cnt_next = 2'h0;
    end
    case (state_reg)
      ST_RUN: begin
        // accepted at an instruction boundary whenever enable is set again
        if (accept) begin
          state_next = ST_PUSH;
        end else if (HALT_INSTR_I) begin
          state_next   = ST_HALT;
          halt_pc_next = RETURN_PC_I;
        end
      end
      ST_HALT: begin
        // wake and dispatch on enabled request
        if (accept) begin
          state_next = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // page, high step, low step below pointer
        st_we_next    = 1'b1;
        st_addr_next  = sp_base_reg - 8'({6'h0, push_cnt_reg} + 8'h1);
        case (push_cnt_reg)
          2'h0:    st_data_next = ret_pc_reg[11:8];
          2'h1:    st_data_next = ret_pc_reg[7:4];
          default: st_data_next = ret_pc_reg[3:0];
        endcase
        push_cnt_next = push_cnt_reg + 2'h1;
        if (push_cnt_reg == STACK_WORDS - 2'h1) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        pc_load_next = 1'b1;
        pc_next      = {VEC_PAGE, step_reg};
        npp_next     = VEC_PAGE;
        sp_load_next = 1'b1;
        sp_val_next  = sp_base_reg - {6'h0, STACK_WORDS};
        state_next   = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // State registers
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      key_armed_reg <= 4'h0;
      key_mask_reg  <= RST_KEY_MASK;
      tmr_mask_reg  <= RST_TMR_MASK;
      // enable, counter and page pointer initialised
      gie_reg       <= RST_GIE;
      pc_load_reg   <= 1'b1;
      pc_reg        <= {VEC_PAGE, STEP_RESET};
      npp_reg       <= RST_NPP;
      rdata_reg     <= 32'h0;
      err_reg       <= 1'b0;
      rclr_reg      <= 6'h0;
      state_reg     <= ST_RUN;
      push_cnt_reg  <= 2'h0;
      ret_pc_reg    <= 12'h0;
      halt_pc_reg   <= 12'h0;
      sp_base_reg   <= 8'h0;
      step_reg      <= STEP_RESET;
      st_we_reg     <= 1'b0;
      st_addr_reg   <= 8'h0;
      st_data_reg   <= 4'h0;
      sp_load_reg   <= 1'b0;
      sp_val_reg    <= 8'h0;
    end else begin
      key_armed_reg <= key_armed_next;
      key_mask_reg  <= key_mask_next;
      tmr_mask_reg  <= tmr_mask_next;
      gie_reg       <= gie_next;
      pc_load_reg   <= pc_load_next;
      pc_reg        <= pc_next;
      npp_reg       <= npp_next;
      rdata_reg     <= rdata_next;
      err_reg       <= err_next;
      rclr_reg      <= rclr_next;
      state_reg     <= state_next;
      push_cnt_reg  <= push_cnt_next;
      ret_pc_reg    <= ret_pc_next;
      halt_pc_reg   <= halt_pc_next;
      sp_base_reg   <= sp_base_next;
      step_reg      <= step_next;
      st_we_reg     <= st_we_next;
      st_addr_reg   <= st_addr_next;
      st_data_reg   <= st_data_next;
      sp_load_reg   <= sp_load_next;
      sp_val_reg    <= sp_val_next;
    end
  end

  // APB outputs
  always_comb begin
    PREADY_O  = access;
    PSLVERR_O = access & err_reg;
    PRDATA_O  = rdata_reg;
  end

  // core clock held off while halted
  always_comb begin
    CORE_CLK_EN_O = (state_reg != ST_HALT);
  end

  // Core-side outputs
  assign GIE_O               = gie_reg;
  assign PC_LOAD_O           = pc_load_reg;
  assign PROGRAM_COUNTER_O   = pc_reg;
  assign NEXT_PAGE_POINTER_O = npp_reg;
  assign STACK_WE_O          = st_we_reg;
  assign STACK_ADDR_O        = st_addr_reg;
  assign STACK_DATA_O        = st_data_reg;
  assign SP_LOAD_O           = sp_load_reg;
  assign SP_VALUE_O          = sp_val_reg;

endmodule : ihc_top

// >>> src/ihc_pkg.sv
// Constants and types shared by the interrupt and halt control block
package ihc_pkg;

  // Clock and timer timing
  localparam int CLK_PERIOD_NS = 10;
  // Half period of the 32 Hz timer signal, in ns
  localparam int FAST_HALF_NS  = 15625000;
  localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_KEY_MASK = 8'he8;
  localparam logic [7:0] IDX_TMR_MASK = 8'heb;
  localparam logic [7:0] IDX_KEY_FLAG = 8'hed;
  localparam logic [7:0] IDX_TMR_FLAG = 8'hef;
  localparam logic [7:0] IDX_STATUS   = 8'he0;
  localparam logic [7:0] IDX_SW_FLAG  = 8'he1;

  // Flag vector layout inside the flag store
  localparam int FLG_TMR_LSB = 0;
  localparam int FLG_KEY     = 3;
  localparam int FLG_SW_LSB  = 4;
  localparam int FLG_COUNT   = 6;

  // Status register fields
  localparam int ST_GIE_BIT  = 0;
  localparam int ST_HALT_BIT = 1;
  localparam int ST_PEND_BIT = 2;

  // Divider taps for 32 Hz, 8 Hz and 2 Hz
  localparam int TAP_FAST = 0;
  localparam int TAP_MID  = 2;
  localparam int TAP_SLOW = 4;

  // Reset values
  localparam logic [3:0] RST_KEY_MASK = 4'h0;
  localparam logic [2:0] RST_TMR_MASK = 3'h0;
  localparam logic       RST_GIE      = 1'b0;
  localparam logic [3:0] RST_NPP      = 4'h1;

  // Vector map, page and steps
  localparam logic [3:0] VEC_PAGE   = 4'h1;
  localparam logic [7:0] STEP_RESET = 8'h00;
  localparam logic [7:0] STEP_TIMER = 8'h01;
  localparam logic [7:0] STEP_KEY   = 8'h04;
  localparam logic [7:0] STEP_BOTH  = 8'h05;

  // Words pushed on interrupt entry
  localparam logic [1:0] STACK_WORDS = 2'h3;

  // Dispatch sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_PUSH,
    ST_LOAD
  } ihc_state_e;

endpackage : ihc_pkg

// >>> src/ihc_flag_if.sv
// Signals between the timer, the flag store and the control logic
`timescale 1ns/1ps
interface ihc_flag_if;
  logic [2:0] tmr_fall;
  logic       key_set;
  logic [1:0] sw_set;
  logic [5:0] clr_v;
  logic [5:0] flag_v;

  modport tmr (output tmr_fall);
  modport flg (input tmr_fall, input key_set, input sw_set,
               input clr_v, output flag_v);
  modport ctl (output key_set, output sw_set, output clr_v,
               input flag_v);
endinterface : ihc_flag_if

// >>> src/ihc_timer.sv
// Clock timer divider producing 32, 8 and 2 Hz falling-edge pulses
`timescale 1ns/1ps
module ihc_timer #(
  parameter int HALF_TICKS = ihc_pkg::FAST_HALF_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Timer pulses
  ihc_flag_if.tmr   fif
);
  import ihc_pkg::*;

  logic [31:0] pre_reg;
  logic [31:0] pre_next;
  logic [4:0]  div_reg;
  logic [4:0]  div_next;
  logic        tick;

  // Prescaler and toggle chain
  always_comb begin
    tick     = (pre_reg == 32'(HALF_TICKS - 1));
    pre_next = tick ? 32'h0 : pre_reg + 32'h1;
    div_next = tick ? div_reg + 5'h1 : div_reg;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pre_reg <= 32'h0;
      div_reg <= 5'h0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
    end
  end

  always_comb begin
    fif.tmr_fall[0] = tick & div_reg[TAP_FAST] & ~div_next[TAP_FAST];
    fif.tmr_fall[1] = tick & div_reg[TAP_MID] & ~div_next[TAP_MID];
    fif.tmr_fall[2] = tick & div_reg[TAP_SLOW] & ~div_next[TAP_SLOW];
  end

endmodule : ihc_timer

// >>> src/ihc_flags.sv
// Interrupt factor flag store with set-over-clear priority
`timescale 1ns/1ps
module ihc_flags (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Set, clear and flag values
  ihc_flag_if.flg   fif
);
  import ihc_pkg::*;

  logic [FLG_COUNT-1:0] flag_reg;
  logic [FLG_COUNT-1:0] flag_next;
  logic [FLG_COUNT-1:0] set_v;

  // Gather set sources in flag order
  always_comb begin
    set_v = {fif.sw_set, fif.key_set, fif.tmr_fall};
  end

  // read clears, a new set wins
  genvar g;
  generate
    for (g = 0; g < FLG_COUNT; g++) begin : g_flag
      always_comb begin
        flag_next[g] = set_v[g] | (flag_reg[g] & ~fif.clr_v[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign fif.flag_v = flag_reg;

endmodule : ihc_flags

// >>> tb/ihc_top_sva.sv
// Checker for the interrupt and halt control block
`timescale 1ns/1ps
module ihc_top_sva (
  // Clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        SRST_I,
  // Core side
  input wire logic        GLOBAL_UNMASK_INSTR_I,
  input wire logic [7:0]  STACK_PTR_I,
  input wire logic        CORE_CLK_EN_O,
  input wire logic        GIE_O,
  input wire logic        PC_LOAD_O,
  input wire logic [11:0] PROGRAM_COUNTER_O,
  input wire logic [3:0]  NEXT_PAGE_POINTER_O,
  input wire logic        STACK_WE_O,
  input wire logic [7:0]  STACK_ADDR_O,
  input wire logic        SP_LOAD_O,
  input wire logic [7:0]  SP_VALUE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  // Dispatch sequence properties
  property p_gie_clr;
    STACK_WE_O |-> !GIE_O;
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("enable set in push");
  property p_take_gie;
    $rose(STACK_WE_O) |-> $past(GIE_O, 2);
  endproperty
  a_take_gie: assert property (p_take_gie) else $error("take without enable");
  property p_push3;
    $rose(STACK_WE_O) |-> STACK_WE_O[*3] ##1
      (!STACK_WE_O && PC_LOAD_O && SP_LOAD_O);
  endproperty
  a_push3: assert property (p_push3) else $error("push count wrong");
  property p_push_addr;
    $rose(STACK_WE_O) |-> STACK_ADDR_O == STACK_PTR_I - 8'h1 ##1
      STACK_ADDR_O == STACK_PTR_I - 8'h2 ##1
      STACK_ADDR_O == STACK_PTR_I - 8'h3;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address");
  property p_sp;
    SP_LOAD_O |-> SP_VALUE_O == STACK_PTR_I - 8'h3;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer value");
  property p_vec;
    SP_LOAD_O |-> NEXT_PAGE_POINTER_O == 4'h1 &&
      PROGRAM_COUNTER_O inside {12'h101, 12'h104, 12'h105};
  endproperty
  a_vec: assert property (p_vec) else $error("vector outside map");

  // Halt and reset properties
  property p_halt_hold;
    !CORE_CLK_EN_O && !GIE_O && !GLOBAL_UNMASK_INSTR_I |=> !CORE_CLK_EN_O;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("woke unasked");
  property p_wake;
    $rose(CORE_CLK_EN_O) && !$past(SRST_I) |-> !GIE_O ##1 STACK_WE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without dispatch");
  property p_rst;
    $fell(SRST_I) |-> !GIE_O && PC_LOAD_O && NEXT_PAGE_POINTER_O == 4'h1
      && PROGRAM_COUNTER_O == 12'h100;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : ihc_top_sva

bind ihc_top ihc_top_sva u_sva (.CLK_SYS_I, .SRST_I, .GLOBAL_UNMASK_INSTR_I,
  .STACK_PTR_I, .CORE_CLK_EN_O, .GIE_O, .PC_LOAD_O, .PROGRAM_COUNTER_O,
  .NEXT_PAGE_POINTER_O, .STACK_WE_O, .STACK_ADDR_O, .SP_LOAD_O, .SP_VALUE_O);

// >>> tb/ihc_core_model.sv
// Behavioural core: paces instructions, keeps PC, stack and SP
`timescale 1ns/1ps
module ihc_core_model (
  // Clock, reset and pacing
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [1:0]  gap_i,
  // Block outputs
  input  wire logic        clk_en_i,
  input  wire logic        pc_load_i,
  input  wire logic [11:0] pc_i,
  input  wire logic        stack_we_i,
  input  wire logic [7:0]  stack_addr_i,
  input  wire logic [3:0]  stack_data_i,
  input  wire logic        sp_load_i,
  input  wire logic [7:0]  sp_value_i,
  // Core state seen by the block
  output logic             boundary_o,
  output logic      [11:0] ret_pc_o,
  output logic      [7:0]  sp_o
);
  logic [3:0] mem [256];
  logic [1:0] cnt;

  // Boundaries only while clocked, PC and stack updates
  always @(posedge clk_i) begin
    if (stack_we_i) mem[stack_addr_i] <= stack_data_i;
    if (srst_i) begin
      cnt <= 2'h0;
      boundary_o <= 1'b0;
      ret_pc_o <= 12'h100;
      sp_o <= 8'h50;
    end else begin
      boundary_o <= clk_en_i && cnt == 2'h0;
      if (clk_en_i) cnt <= (cnt == 2'h0) ? gap_i : cnt - 2'h1;
      if (pc_load_i) ret_pc_o <= pc_i;
      else if (boundary_o) ret_pc_o <= ret_pc_o + 12'h1;
      if (sp_load_i) sp_o <= sp_value_i;
    end
  end
endmodule : ihc_core_model

// >>> tb/tb.sv
// Self-checking bench for the interrupt and halt control block
`timescale 1ns/1ps
module tb;
  import ihc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  keys = 4'h0;
  logic [1:0]  sw = 2'h0;
  logic [2:0]  ctl = 3'h0;
  logic [1:0]  gap = 2'h0;
  logic [31:0] prd;
  logic        prdy, perr, cken, gie, pcld, we, spld, bnd;
  logic [11:0] pc, rpc, ret_cap;
  logic [7:0]  sa, sp, spv;
  logic [3:0]  sd, next_page_pointer;
  logic [32:0] e;
  logic [12:0] v;
  logic [31:0] k;
  logic [32:0] rq[$];
  logic [12:0] vq[$];
  int          error_cnt = 0;
  int          n_compared = 0;

  ihc_top #(.HALF_TICKS(4)) DUT (.CLK_SYS_I(clk), .SRST_I(srst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
    .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .KEY_INPUT_LINES_I(keys), .STOPWATCH_SET_I(sw),
    .INSTR_BOUNDARY_I(bnd), .GLOBAL_UNMASK_INSTR_I(ctl[0]),
    .GLOBAL_MASK_INSTR_I(ctl[1]), .HALT_INSTR_I(ctl[2]),
    .RETURN_PC_I(rpc), .STACK_PTR_I(sp), .CORE_CLK_EN_O(cken),
    .GIE_O(gie), .PC_LOAD_O(pcld), .PROGRAM_COUNTER_O(pc),
    .NEXT_PAGE_POINTER_O(next_page_pointer), .STACK_WE_O(we), .STACK_ADDR_O(sa),
    .STACK_DATA_O(sd), .SP_LOAD_O(spld), .SP_VALUE_O(spv));
  ihc_core_model core (.clk_i(clk), .srst_i(srst), .gap_i(gap),
    .clk_en_i(cken), .pc_load_i(pcld), .pc_i(pc), .stack_we_i(we),
    .stack_addr_i(sa), .stack_data_i(sd), .sp_load_i(spld),
    .sp_value_i(spv), .boundary_o(bnd), .ret_pc_o(rpc), .sp_o(sp));

  // Clock
  always #5 clk = ~clk;

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] s);
    n_compared++;
    if (ex !== s) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, ex, s);
    end
  endtask : chk

  // APB transfer held until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd(logic [11:0] a, logic er, logic [31:0] d);
    rq.push_back({er, d});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic ins(logic [2:0] c);
    @(posedge clk);
    ctl <= c;
    @(posedge clk);
    ctl <= 3'h0;
  endtask : ins

  // Waits for noted dispatches, then a quiet span
  task automatic settle(string nm);
    for (int i = 0; i < 300 && vq.size() != 0; i++) @(posedge clk);
    chk("dispatches left", 32'h0, 32'(vq.size()));
    repeat (10) @(posedge clk);
    $display("test %s done", nm);
  endtask : settle

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Result monitor against the noted expectations
  always @(posedge clk) begin
    if (ctl[2] && cken) ret_cap <= rpc;
    if (psel && pen && prdy && !pwr) begin
      e = rq.size() ? rq.pop_front() : 33'h1_ffff_ffff;
      chk("read data", e[31:0], prd);
      chk("slave error", {31'h0, e[32]}, {31'h0, perr});
    end
    if (pcld && spld) begin
      v = vq.size() ? vq.pop_front() : 13'h0;
      chk("vector", {20'h0, v[11:0]}, {20'h0, pc});
      if (v[12]) chk("stacked pc", {20'h0, ret_cap}, {20'h0,
        core.mem[sp - 8'h1], core.mem[sp - 8'h2], core.mem[sp - 8'h3]});
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(8943));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(12'h380, 1'b0, 32'h0);
    k = $urandom;
    gap <= k[5:4];
    apb(1'b1, 12'h3a0, k);
    rd(12'h3a0, 1'b0, {28'h0, k[3:0]});
    apb(1'b1, 12'h3ac, 32'hf);
    rd(12'h3ac, 1'b0, 32'h7);
    rd(12'h3f0, 1'b1, 32'h0);
    rd(12'h3a1, 1'b1, 32'h0);
    apb(1'b1, 12'h3a0, 32'h0);
    apb(1'b1, 12'h3ac, 32'h0);
    repeat (140) @(posedge clk);
    rd(12'h3bc, 1'b0, 32'h7);
    @(posedge clk);
    sw <= 2'h3;
    @(posedge clk);
    sw <= 2'h0;
    rd(12'h384, 1'b0, 32'h3);
    rd(12'h384, 1'b0, 32'h0);
    // Flag set before setup, set again at the clearing edge
    fork
      rd(12'h384, 1'b0, 32'h1);
      begin
        sw <= 2'h1;
        @(posedge clk);
        sw <= 2'h0;
        @(posedge clk);
        sw <= 2'h1;
        @(posedge clk);
        sw <= 2'h0;
      end
    join
    rd(12'h384, 1'b0, 32'h1);
    settle("registers and flags");
    // masked lines, then unmask while high
    k = $urandom_range(3, 0);
    keys <= 4'hf;
    repeat (5) @(posedge clk);
    rd(12'h3b4, 1'b0, 32'h0);
    apb(1'b1, 12'h3a0, 32'h1 << k[1:0]);
    repeat (4) @(posedge clk);
    rd(12'h3b4, 1'b0, 32'h1);
    keys <= 4'h0;
    rd(12'h3b4, 1'b0, 32'h0);
    settle("key flag");
    // halt, then wake by enable with pending key
    keys <= 4'h1 << k[1:0];
    repeat (5) @(posedge clk);
    ins(3'b100);
    repeat (20) @(posedge clk);
    chk("clock enable", 32'h0, {31'h0, cken});
    rd(12'h380, 1'b0, 32'h6);
    vq.push_back({1'b1, 12'h104});
    ins(3'b001);
    settle("halt wake");
    chk("global enable", 32'h0, {31'h0, gie});
    // unread flag raises again, read flag stops it
    vq.push_back({1'b0, 12'h104});
    ins(3'b001);
    settle("repeat");
    rd(12'h3b4, 1'b0, 32'h1);
    ins(3'b001);
    settle("no repeat");
    vq.push_back({1'b0, 12'h101});
    apb(1'b1, 12'h3ac, 32'h1);
    settle("timer dispatch");
    keys <= 4'h0;
    repeat (4) @(posedge clk);
    keys <= 4'h1 << k[1:0];
    repeat (5) @(posedge clk);
    vq.push_back({1'b0, 12'h105});
    ins(3'b001);
    settle("both pending");
    ins(3'b011);
    settle("disable wins");
    chk("global enable", 32'h0, {31'h0, gie});
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(12'h3ac, 1'b0, 32'h0);
    rd(12'h380, 1'b0, 32'h0);
    settle("second reset");
    tally_and_finish();
  end
endmodule : tb
